// ===== ssc_defines.svh
/*
  offsets, field positions, reset values and bus widths of the synchronous start control block.
  assumes inclusion by bare name from design files; definitions only.
*/
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

`define SSC_ADDR_W        13
`define SSC_OFF_W         12
`define SSC_UNIT_BIT      12
`define SSC_CTRL_OFF      12'h110
`define SSC_TRIG_OFF      12'h114
`define SSC_UNIT_B_BASE   13'h1000
`define SSC_CH_N          6

`define SSC_SRC_MSB       9
`define SSC_SRC_LSB       8
`define SSC_JOIN_CH0_BIT  0
`define SSC_JOIN_CH2_BIT  2
`define SSC_JOIN_CH4_BIT  4
`define SSC_TRIG_BIT      0

`define SSC_CTRL_RESET    32'h0000_0000

`endif

// ===== ssc_pkg.sv
/*
  types of the synchronous start control block: bus request carrier, source select, control fields.
  assumes ssc_defines.svh is on the include path.
*/
`default_nettype none
`include "ssc_defines.svh"

package ssc_pkg;

  typedef enum logic [1:0] {
    SSC_SRC_FULL_A  = 2'h0,
    SSC_SRC_FULL_B  = 2'h1,
    SSC_SRC_BASIC_A = 2'h2,
    SSC_SRC_BASIC_B = 2'h3
  } ssc_src_t;

  typedef struct packed {
    logic [`SSC_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
  } ssc_req_t;

  typedef struct packed {
    ssc_src_t sync_start_source_select;
    logic     sync_join_enable_ch4;
    logic     sync_join_enable_ch2;
    logic     sync_join_enable_ch0;
  } ssc_ctrl_t;

  typedef struct packed {
    logic basic_b;
    logic basic_a;
    logic full_b;
    logic full_a;
  } ssc_events_t;

endpackage : ssc_pkg

`default_nettype wire

// ===== ssc_sync_start.sv
/*
  synchronous start control for two full pwm units: control registers for both units,
  the write-only start trigger in unit a's space, and per-channel counter run enable set pulses.
  assumes: register port synchronous to mclk, one strobe per cycle; start events from full unit b
  and the basic units arrive as one-cycle pulses on mclk; the counters outside own the run enables
  and only take the set pulses from here.
  limitation: a start only ever sets run enables; clearing them is left to the counters,
  so a channel that has not joined is never touched from here.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ssc_defines.svh"

// Summary of operation
// - two-bit source select picks start origin: full a, full b, basic a, basic b.
// - channel 0 join enable lets a start set channel 0 run enable.
// - channel 2 join enable lets a start set channel 2 run enable.
// - channel 4 join enable lets a start set channel 4 run enable.
// - writing 1 to trigger bit sets run enables of joined channels in each unit whose source select is full a.
// - joined channels of both full units start counting in the same cycle when both select the same origin.
// - trigger register is write-only; bit 0 works, upper bits reserved.
// - trigger bit exists only in unit a register space.
module ssc_sync_start (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire ssc_pkg::ssc_req_t req,
  output var  logic [31:0]       rdata,
  input  wire logic              start_event_full_b,
  input  wire logic              start_event_basic_a,
  input  wire logic              start_event_basic_b,
  output var  logic              start_event_full_a,
  output var  logic [5:0]        counter_run_enable_set_a,
  output var  logic [5:0]        counter_run_enable_set_b
);

  // channels 1, 3, 5 have no join enable and are never set here
  function automatic logic [`SSC_CH_N-1:0] join_mask(input ssc_pkg::ssc_ctrl_t c);
    join_mask = '0;
    join_mask[0] = c.sync_join_enable_ch0;
    join_mask[2] = c.sync_join_enable_ch2;
    join_mask[4] = c.sync_join_enable_ch4;
  endfunction : join_mask

  function automatic logic [31:0] ctrl_word(input ssc_pkg::ssc_ctrl_t c);
    ctrl_word = `SSC_CTRL_RESET;
    ctrl_word[`SSC_SRC_MSB:`SSC_SRC_LSB] = c.sync_start_source_select;
    ctrl_word[`SSC_JOIN_CH0_BIT] = c.sync_join_enable_ch0;
    ctrl_word[`SSC_JOIN_CH2_BIT] = c.sync_join_enable_ch2;
    ctrl_word[`SSC_JOIN_CH4_BIT] = c.sync_join_enable_ch4;
  endfunction : ctrl_word

  function automatic ssc_pkg::ssc_ctrl_t ctrl_from_word(input logic [31:0] w);
    ctrl_from_word.sync_start_source_select = ssc_pkg::ssc_src_t'(w[`SSC_SRC_MSB:`SSC_SRC_LSB]);
    ctrl_from_word.sync_join_enable_ch0     = w[`SSC_JOIN_CH0_BIT];
    ctrl_from_word.sync_join_enable_ch2     = w[`SSC_JOIN_CH2_BIT];
    ctrl_from_word.sync_join_enable_ch4     = w[`SSC_JOIN_CH4_BIT];
  endfunction : ctrl_from_word

  // one origin per unit, chosen by its own source select
  function automatic logic pick_event(input ssc_pkg::ssc_src_t s, input ssc_pkg::ssc_events_t e);
    case (s)
      ssc_pkg::SSC_SRC_FULL_A:  pick_event = e.full_a;
      ssc_pkg::SSC_SRC_FULL_B:  pick_event = e.full_b;
      ssc_pkg::SSC_SRC_BASIC_A: pick_event = e.basic_a;
      ssc_pkg::SSC_SRC_BASIC_B: pick_event = e.basic_b;
      default:                  pick_event = 1'b0;
    endcase
  endfunction : pick_event

  function automatic logic is_ctrl_off(input ssc_pkg::ssc_req_t r);
    is_ctrl_off = (r.addr[`SSC_OFF_W-1:0] == `SSC_CTRL_OFF);
  endfunction : is_ctrl_off

  function automatic logic is_trig_off(input ssc_pkg::ssc_req_t r);
    is_trig_off = (r.addr[`SSC_OFF_W-1:0] == `SSC_TRIG_OFF);
  endfunction : is_trig_off

  // address bit 12 picks full unit b; both units share the same offsets
  function automatic logic unit_of(input ssc_pkg::ssc_req_t r);
    unit_of = r.addr[`SSC_UNIT_BIT];
  endfunction : unit_of

  ssc_pkg::ssc_ctrl_t [1:0]    ctrl_q;
  ssc_pkg::ssc_ctrl_t [1:0]    ctrl_d;
  logic [31:0]                 rdata_q;
  logic [31:0]                 rdata_d;
  logic                        start_a_q;
  logic                        start_a_d;
  logic [5:0]                  set_a_q;
  logic [5:0]                  set_a_d;
  logic [5:0]                  set_b_q;
  logic [5:0]                  set_b_d;
  logic                        unit_sel;
  logic                        ctrl_wr;
  logic                        ctrl_rd;
  logic                        trig_wr;
  logic                        trig_fire;
  ssc_pkg::ssc_src_t           src_a;
  ssc_pkg::ssc_src_t           src_b;
  logic [`SSC_CH_N-1:0]        mask_a;
  logic [`SSC_CH_N-1:0]        mask_b;
  logic                        fire_a;
  logic                        fire_b;
  ssc_pkg::ssc_events_t        events;

  // request decode; the master never raises both strobes in one cycle
  always_comb begin
    unit_sel  = unit_of(req);
    ctrl_wr   = req.wr && is_ctrl_off(req);
    ctrl_rd   = req.rd && is_ctrl_off(req);
    trig_wr   = req.wr && is_trig_off(req) && !unit_of(req);
    trig_fire = trig_wr && req.wdata[`SSC_TRIG_BIT];
  end

  // a control write lands at its taking edge; the other unit keeps its word
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d[unit_sel] = ctrl_from_word(req.wdata);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // trigger word reads as zero like any unmapped word; its upper bits are ignored
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (ctrl_rd) begin
      rdata_d = ctrl_word(ctrl_q[unit_sel]);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // software start of unit a, also handed out as the full unit a source of other units
  always_comb begin
    start_a_d = 1'b0;
    if (trig_fire) begin
      start_a_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      start_a_q <= 1'b0;
    end else begin
      start_a_q <= start_a_d;
    end
  end

  // unit a's trigger is taken in its write cycle, not from the registered pulse,
  // so it reaches both units in step with the external sources
  always_comb begin
    events.full_a  = trig_fire;
    events.full_b  = start_event_full_b;
    events.basic_a = start_event_basic_a;
    events.basic_b = start_event_basic_b;
  end

  // masks follow the stored words, so a write in the event cycle does not count yet
  always_comb begin
    mask_a = join_mask(ctrl_q[0]);
    mask_b = join_mask(ctrl_q[1]);
  end

  always_comb begin
    src_a  = ctrl_q[0].sync_start_source_select;
    src_b  = ctrl_q[1].sync_start_source_select;
    fire_a = pick_event(src_a, events);
    fire_b = pick_event(src_b, events);
  end

  // both units decide from one event set in one cycle, so joined counters start together
  always_comb begin
    set_a_d = 6'h00;
    if (fire_a) begin
      set_a_d = mask_a;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      set_a_q <= 6'h00;
    end else begin
      set_a_q <= set_a_d;
    end
  end

  // only set pulses leave here, so channels outside the mask keep their run enables
  always_comb begin
    set_b_d = 6'h00;
    if (fire_b) begin
      set_b_d = mask_b;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      set_b_q <= 6'h00;
    end else begin
      set_b_q <= set_b_d;
    end
  end

  assign rdata                    = rdata_q;
  assign start_event_full_a       = start_a_q;
  assign counter_run_enable_set_a = set_a_q;
  assign counter_run_enable_set_b = set_b_q;

endmodule : ssc_sync_start

`default_nettype wire

// ===== ssc_sync_start_props.sv
/*
  checker for the synchronous start control block: concurrent assertions on its ports.
  assumes mclk as the only clock and nrst as an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ssc_sync_start_props (
  input wire logic              mclk,
  input wire logic              nrst,
  input wire ssc_pkg::ssc_req_t req,
  input wire logic [31:0]       rdata,
  input wire logic              start_event_full_b,
  input wire logic              start_event_basic_a,
  input wire logic              start_event_basic_b,
  input wire logic              start_event_full_a,
  input wire logic [5:0]        counter_run_enable_set_a,
  input wire logic [5:0]        counter_run_enable_set_b
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic trig;
  logic ev;
  assign trig = req.wr && req.addr == 13'h0114 && req.wdata[0];
  assign ev   = trig || start_event_full_b || start_event_basic_a || start_event_basic_b;
  a_trig_pulse: assert property (trig |=> start_event_full_a) else $error("no start pulse");
  a_trig_only: assert property (!trig |=> !start_event_full_a) else $error("stray start pulse");
  a_unit_b_none: assert property (req.wr && req.addr == 13'h1114 |=> !start_event_full_a)
    else $error("unit b start");
  a_odd_quiet: assert property (ev |=>
    ((counter_run_enable_set_a | counter_run_enable_set_b) & 6'h2a) == 6'h00) else $error("odd channel set");
  a_no_cause: assert property (!ev |=>
    counter_run_enable_set_a == 6'h00 && counter_run_enable_set_b == 6'h00) else $error("set without start");
  a_trig_reads_zero: assert property (req.rd && req.addr[11:0] == 12'h114 |=> rdata == 32'h0)
    else $error("trig read");
  a_rd_idle_zero: assert property (!req.rd |=> rdata == 32'h0) else $error("rdata not idle");
  a_ctrl_rsv_zero: assert property (req.rd && req.addr[11:0] == 12'h110 |=>
    (rdata & 32'hffff_fcea) == 32'h0) else $error("reserved bits set");
  c_trig: cover property (trig);
  c_ext_start: cover property (start_event_full_b ##1 (counter_run_enable_set_a != 6'h00));
  c_ctrl_read: cover property (req.rd && req.addr[11:0] == 12'h110);
endmodule : ssc_sync_start_props
bind ssc_sync_start ssc_sync_start_props u_props (.mclk, .nrst, .req, .rdata, .start_event_full_b,
  .start_event_basic_a, .start_event_basic_b, .start_event_full_a, .counter_run_enable_set_a,
  .counter_run_enable_set_b);
`default_nettype wire

// ===== tb_top.sv
/*
  testbench for the synchronous start control block: register accesses, trigger and event starts.
  assumes the package, design and checker are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic              mclk = 1'b0;
  logic              nrst = 1'b0;
  ssc_pkg::ssc_req_t req  = '0;
  logic [2:0]        ev   = 3'h0;
  logic [31:0]       rdata;
  logic              full_a;
  logic [5:0]        set_a;
  logic [5:0]        set_b;
  logic [31:0]       outs;
  int                n_fail = 0;
  int                num_checks = 0;
  ssc_sync_start dut_u (.mclk(mclk), .nrst(nrst), .req(req), .rdata(rdata), .start_event_full_b(ev[0]),
    .start_event_basic_a(ev[1]), .start_event_basic_b(ev[2]), .start_event_full_a(full_a),
    .counter_run_enable_set_a(set_a), .counter_run_enable_set_b(set_b));
  assign outs = {19'h0, full_a, set_b, set_a};
  initial forever #12.5 mclk = ~mclk;
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // each access ends just after its taking edge, so results are sampled once settled
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    @(posedge mclk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [12:0] a, input logic [31:0] exp);
    @(posedge mclk) req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk) req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  task automatic fire(input int e);
    if (e == 0) begin
      wr(13'h0114, 32'h1);
    end else begin
      @(posedge mclk) ev <= 3'(1 << (e - 1));
      @(posedge mclk) ev <= 3'h0;
      #1;
    end
  endtask : fire
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    rd(13'h0110, 32'h0);
    rd(13'h1110, 32'h0);
    wr(13'h0110, 32'hffff_ffff);
    rd(13'h0110, 32'h0000_0315);
    rd(13'h0114, 32'h0);
    wr(13'h1110, 32'h0000_0004);
    for (int s = 0; s < 4; s++) begin
      wr(13'h0110, 32'(s << 8) | 32'h11);
      for (int e = 0; e < 4; e++) begin
        fire(e);
        chk(outs, {19'h0, e == 0, e == 0 ? 6'h04 : 6'h00, s == e ? 6'h11 : 6'h00});
      end
    end
    wr(13'h0114, 32'hffff_fffe);
    chk(outs, 32'h0);
    wr(13'h1114, 32'h1);
    chk(outs, 32'h0);
    rd(13'h1110, 32'h0000_0004);
    wr(13'h1110, 32'h0000_0104);
    fire(1);
    chk(outs, {19'h0, 1'b0, 6'h04, 6'h00});
    fire(3);
    chk(outs, {19'h0, 1'b0, 6'h00, 6'h11});
    final_report();
  end
  // whole run is near 70 cycles; a hang is cut well beyond that
  initial begin
    repeat (2000) @(posedge mclk);
    n_fail++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
